// >>> inc/sfepc_pkg.sv
// Purpose: shared constants for the serial flash power and erase link
// Assumes: 50 MHz ref_clk_in on both ends
// Notes:   opcodes and times not fixed elsewhere are plain defaults
package sfepc_pkg;
   localparam int unsigned CLK_KHZ     = 50000;
   // command codes
   localparam logic [7:0]  OP_WR_EN    = 8'h06;
   localparam logic [7:0]  OP_RDSR     = 8'h05;
   localparam logic [7:0]  OP_ST_WR    = 8'h01;
   localparam logic [7:0]  OP_ERASE    = 8'hc7;
   localparam logic [7:0]  OP_SLEEP    = 8'hb9;
   localparam logic [7:0]  OP_WAKE     = 8'hab;
   localparam logic [7:0]  SIGNATURE   = 8'h5a; // arbitrary value
   // status layout
   localparam int unsigned SB_BUSY     = 0;
   localparam int unsigned SB_WLATCH   = 1;
   localparam int unsigned SB_BP_LO    = 2;
   localparam int unsigned BP_W        = 3;
   localparam logic [7:0]  STATUS_RST  = 8'h00;
   localparam logic [7:0]  MEM_ERASED  = 8'hff;
   localparam int unsigned MEM_BYTES   = 16;
   localparam int unsigned MEM_AW      = 4;
   localparam logic [2:0]  WAKE_BYTES  = 3'h4;  // opcode plus three dummies
   // times and cycle counts
   localparam int unsigned T_PU_MS     = 10;
   localparam int unsigned T_BE_MS     = 1;
   localparam int unsigned T_DP_US     = 3;
   localparam int unsigned T_RES_US    = 3;
   localparam int unsigned T_W_US      = 10;
   localparam int unsigned T_CS_NS     = 100;
   localparam int unsigned T_SCK_NS    = 160;
   localparam int unsigned T_PU_CYC    = T_PU_MS * CLK_KHZ;
   localparam int unsigned T_BE_CYC    = T_BE_MS * CLK_KHZ;
   localparam int unsigned T_DP_CYC    = (T_DP_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned T_RES_CYC   = (T_RES_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned T_W_CYC     = (T_W_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned T_CS_CYC    = (T_CS_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned SCK_HALF    = T_SCK_NS * CLK_KHZ / 2000000;
   // host register map and fields
   localparam logic [3:0]  HREG_CMD    = 4'h0;
   localparam logic [3:0]  HREG_STAT   = 4'h4;
   localparam int unsigned CF_OP_LO    = 0;
   localparam int unsigned CF_NB_LO    = 8;
   localparam int unsigned CF_DAT_LO   = 16;
   localparam int unsigned HS_RX_LO    = 8;

   typedef enum logic [2:0] {
      DM_PWRUP = 3'b000,
      DM_STBY  = 3'b001,
      DM_GODP  = 3'b010,
      DM_DEEP  = 3'b011,
      DM_WAKE  = 3'b100
   } sfepc_dmode_t;

   typedef enum logic [2:0] {
      HS_PWRUP = 3'b000,
      HS_IDLE  = 3'b001,
      HS_LOW   = 3'b010,
      HS_HIGH  = 3'b011,
      HS_TAIL  = 3'b100,
      HS_GAP   = 3'b101
   } sfepc_hstate_t;
endpackage : sfepc_pkg

// >>> inc/sfepc_link_if.sv
// Purpose: serial link between host controller and flash end
// Assumes: all four wires are one-way
// Notes:   no clocking block; bench joins the two ends here
`timescale 1ns/1ps
interface sfepc_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   modport host (output cs_n, output sck, output si, input so);
   modport dev  (input cs_n, input sck, input si, output so);
endinterface : sfepc_link_if

// >>> rtl/sfepc_sync.sv
// Purpose: two-stage synchroniser for link pins
// Assumes: each bit is an independent level
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sfepc_sync #(
   parameter int unsigned  W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         ref_clk_in,
   input  wire logic         nrst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   // one pair of flops per bit, reset to each pin's idle level
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            meta_r[i] <= RST_VAL[i];
            q_out[i]  <= RST_VAL[i];
         end else begin
            meta_r[i] <= d_in[i];
            q_out[i]  <= meta_r[i];
         end
      end
   end
endmodule : sfepc_sync

// >>> rtl/sfepc_dev.sv
// Purpose: flash end: erase, deep sleep, wake and signature handling
// Assumes: link pins are asynchronous to ref_clk_in, sck well below clk/4
// Notes:   array is a small flop store; nrst_in stands for power-up
`timescale 1ns/1ps
module sfepc_dev import sfepc_pkg::*; #(
   parameter int unsigned T_PU_P = T_PU_CYC,
   parameter int unsigned T_BE_P = T_BE_CYC
) (
   input  wire logic              ref_clk_in,
   input  wire logic              nrst_in,
   sfepc_link_if.dev              link,
   input  wire logic [MEM_AW-1:0] mem_idx_in,
   input  wire logic              mem_wr_in,
   input  wire logic [7:0]        mem_wdata_in,
   output logic      [7:0]        mem_rdata_out,
   output logic      [7:0]        status_out,
   output logic                   deep_out,
   output logic                   ready_out
);
   ///////////////////////////////////////////////////////////////////////////
   logic [2:0]   pin_s;
   logic         cs_q;
   logic         sck_q;
   logic [7:0]   sh_r;
   logic [2:0]   bit_r;
   logic [2:0]   byte_r;
   logic [7:0]   op_r;
   logic [7:0]   dat_r;
   logic [7:0]   out_r;
   logic         so_r;
   sfepc_dmode_t mode_r;
   logic [31:0]  mcnt_r;
   logic         busy_r;
   logic         wlatch_r;
   logic         erase_r;
   logic [31:0]  bcnt_r;
   logic [BP_W-1:0] bp_r;
   logic [7:0]   mem_r [MEM_BYTES];
   logic         sck_rise;
   logic         sck_fall;
   logic         cs_rise;
   logic         at_bound;
   logic         go;
   logic         erase_done;
   logic [7:0]   byte_in;
   logic [7:0]   op_cur;
   logic [2:0]   nb;

   // pins: cs_n, sck, si
   // idle levels: si low, sck low, cs_n high
   sfepc_sync #(.W(3), .RST_VAL(3'h1)) u_sync (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .d_in       ({link.si, link.sck, link.cs_n}),
      .q_out      (pin_s)
   );

   // edge history of the synchronised cs_n and sck
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cs_q  <= 1'b1;
         sck_q <= 1'b0;
      end else begin
         cs_q  <= pin_s[0];
         sck_q <= pin_s[1];
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // rising sck and rising cs_n count only once power-up has elapsed; falling sck is not gated
   assign sck_rise   = pin_s[1] & ~sck_q & ~pin_s[0] & (mode_r != DM_PWRUP);
   assign sck_fall   = ~pin_s[1] & sck_q & ~pin_s[0];
   assign cs_rise    = pin_s[0] & ~cs_q & (mode_r != DM_PWRUP);
   assign at_bound   = (bit_r == 3'h0) && (byte_r != 3'h0);
   assign go         = cs_rise && at_bound && (mode_r == DM_STBY) && !busy_r;
   assign erase_done = busy_r && erase_r && (bcnt_r == 32'h0);
   assign byte_in    = {sh_r[6:0], pin_s[2]};
   assign op_cur     = (byte_r == 3'h0) ? byte_in : op_r;
   assign nb         = (byte_r == WAKE_BYTES) ? byte_r : byte_r + 3'h1;

   // shift in on rising sck, count bits and bytes, pick reply byte
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sh_r   <= 8'h00;
         bit_r  <= 3'h0;
         byte_r <= 3'h0;
         op_r   <= 8'h00;
         dat_r  <= 8'h00;
         out_r  <= 8'h00;
      end else if (pin_s[0]) begin
         bit_r  <= 3'h0;
         byte_r <= 3'h0;
         out_r  <= 8'h00;
      end else if (sck_rise) begin
         sh_r  <= byte_in;
         bit_r <= bit_r + 3'h1;
         if (bit_r == 3'h7) begin
            byte_r <= nb;
            if (byte_r == 3'h0) op_r <= byte_in;
            if (byte_r == 3'h1) dat_r <= byte_in;
            if (op_cur == OP_RDSR && mode_r == DM_STBY) begin
               out_r <= {3'h0, bp_r, wlatch_r, busy_r};
            end else if (op_cur == OP_WAKE && nb == WAKE_BYTES && !busy_r
                         && mode_r != DM_WAKE) begin
               out_r <= SIGNATURE;
            end
         end
      end else if (sck_fall) begin
         out_r <= {out_r[6:0], 1'b0};
      end
   end

   // serial output changes after falling sck
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) so_r <= 1'b0;
      else if (pin_s[0]) so_r <= 1'b0;
      else if (sck_fall) so_r <= out_r[7];
   end
   assign link.so = so_r;

   ///////////////////////////////////////////////////////////////////////////
   // power mode: power-up wait, standby, sleep entry, sleep, wake delay
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_r <= DM_PWRUP;
         mcnt_r <= 32'h0;
      end else begin
         case (mode_r)
            DM_PWRUP: begin
               mcnt_r <= mcnt_r + 32'h1;
               if (mcnt_r >= T_PU_P - 1) begin
                  mode_r <= DM_STBY;
                  mcnt_r <= 32'h0;
               end
            end
            DM_STBY: begin
               if (go && op_r == OP_SLEEP && byte_r == 3'h1) begin
                  mode_r <= DM_GODP;
                  mcnt_r <= 32'h0;
               end
               // wake outside sleep: nothing to undo, stays in standby
            end
            DM_GODP, DM_DEEP: begin
               mcnt_r <= mcnt_r + 32'h1;
               if (mode_r == DM_GODP && mcnt_r >= T_DP_CYC - 1) begin
                  mode_r <= DM_DEEP;
               end
               if (cs_rise && at_bound && op_r == OP_WAKE) begin
                  mode_r <= DM_WAKE;
                  mcnt_r <= 32'h0;
               end
            end
            DM_WAKE: begin
               mcnt_r <= mcnt_r + 32'h1;
               if (mcnt_r >= T_RES_CYC - 1) begin
                  mode_r <= DM_STBY;
                  mcnt_r <= 32'h0;
               end
            end
            default: begin
               mode_r <= DM_STBY;
               mcnt_r <= 32'h0;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // write latch, protect bits and the self-timed cycle
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_r   <= STATUS_RST[SB_BUSY];
         wlatch_r <= STATUS_RST[SB_WLATCH];
         bp_r     <= STATUS_RST[SB_BP_LO +: BP_W];
         erase_r  <= 1'b0;
         bcnt_r   <= 32'h0;
      end else if (busy_r) begin
         bcnt_r <= bcnt_r - 32'h1;
         if (bcnt_r == 32'h0) busy_r <= 1'b0;
      end else if (go) begin
         if (op_r == OP_WR_EN && byte_r == 3'h1) begin
            wlatch_r <= 1'b1;
         end else if (op_r == OP_ERASE && byte_r == 3'h1 && wlatch_r
                      && bp_r == '0) begin
            busy_r   <= 1'b1;
            wlatch_r <= 1'b0;
            erase_r  <= 1'b1;
            bcnt_r   <= T_BE_P - 1;
         end else if (op_r == OP_ST_WR && byte_r == 3'h2 && wlatch_r) begin
            bp_r     <= dat_r[SB_BP_LO +: BP_W];
            busy_r   <= 1'b1;
            wlatch_r <= 1'b0;
            erase_r <= 1'b0;
            bcnt_r  <= T_W_CYC - 1;
         end
      end
   end

   // array store: erase fills ff, user port presets bytes when idle
   for (genvar i = 0; i < MEM_BYTES; i++) begin : g_mem
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
         if (!nrst_in) mem_r[i] <= MEM_ERASED;
         else if (erase_done) mem_r[i] <= MEM_ERASED;
         else if (mem_wr_in && !busy_r && mem_idx_in == MEM_AW'(i)) begin
            mem_r[i] <= mem_wdata_in;
         end
      end
   end

   // registered user-side view
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_rdata_out <= MEM_ERASED;
         status_out    <= STATUS_RST;
         deep_out      <= 1'b0;
         ready_out     <= 1'b0;
      end else begin
         mem_rdata_out <= mem_r[mem_idx_in];
         status_out    <= {3'h0, bp_r, wlatch_r, busy_r};
         deep_out      <= (mode_r == DM_DEEP);
         ready_out     <= (mode_r == DM_STBY);
      end
   end
endmodule : sfepc_dev

// >>> rtl/sfepc_host.sv
// Purpose: host end: drives the serial link from two Avalon-MM registers
// Assumes: sck derived from ref_clk_in by a divider
// Notes:   so comes from logic on the same clock, read directly
`timescale 1ns/1ps
module sfepc_host import sfepc_pkg::*; #(
   parameter int unsigned T_PU_P = T_PU_CYC
) (
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   sfepc_link_if.host       link
);
   sfepc_hstate_t st_r;
   logic [31:0]   cnt_r;
   logic [7:0]    op_r;
   logic [7:0]    dat_r;
   logic [7:0]    sh_r;
   logic [7:0]    rx_r;
   logic [7:0]    rxb_r;
   logic [5:0]    bits_r;
   logic [2:0]    bib_r;
   logic          cs_r;
   logic          sck_r;
   logic          si_r;
   logic          take;
   logic          start;
   logic [7:0]    wop;

   ///////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then answer
   assign take  = (avs_read_in || avs_write_in) && avs_waitrequest_out;
   assign wop   = avs_writedata_in[CF_OP_LO +: 8];
   assign start = take && avs_write_in && avs_address_in == HREG_CMD && st_r == HS_IDLE;

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0;
      end else begin
         avs_waitrequest_out <= !take;
         if (take && avs_read_in) begin
            if (avs_address_in == HREG_CMD) avs_readdata_out <= {8'h0, dat_r, 8'h0, op_r};
            else if (avs_address_in == HREG_STAT) begin
               avs_readdata_out <= {16'h0, rxb_r, 6'h0, st_r != HS_PWRUP, st_r != HS_IDLE};
            end else avs_readdata_out <= 32'h0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // frame sequencer
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r   <= HS_PWRUP;
         cnt_r  <= 32'h0;
         op_r   <= 8'h00;
         dat_r  <= 8'h00;
         sh_r   <= 8'h00;
         rx_r   <= 8'h00;
         rxb_r  <= 8'h00;
         bits_r <= 6'h0;
         bib_r  <= 3'h0;
         cs_r   <= 1'b1;
         sck_r  <= 1'b0;
         si_r   <= 1'b0;
      end else begin
         case (st_r)
            HS_PWRUP: begin
               cnt_r <= cnt_r + 32'h1;
               if (cnt_r >= T_PU_P - 1) st_r <= HS_IDLE;
            end
            HS_IDLE: begin
               if (start) begin
                  op_r  <= wop;
                  dat_r <= avs_writedata_in[CF_DAT_LO +: 8];
                  sh_r  <= wop;
                  si_r  <= wop[7];
                  bib_r <= 3'h0;
                  // erase goes out as a lone opcode
                  if (wop == OP_ERASE) bits_r <= 6'h7;
                  else bits_r <= {avs_writedata_in[CF_NB_LO +: 3], 3'h7};
                  cs_r  <= 1'b0;
                  cnt_r <= SCK_HALF - 1;
                  st_r  <= HS_LOW;
               end
            end
            HS_LOW: begin
               cnt_r <= cnt_r - 32'h1;
               if (cnt_r == 32'h0) begin
                  sck_r <= 1'b1;
                  cnt_r <= SCK_HALF - 1;
                  st_r  <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               cnt_r <= cnt_r - 32'h1;
               if (cnt_r == 32'h0) begin
                  rx_r  <= {rx_r[6:0], link.so};
                  if (bib_r == 3'h7) rxb_r <= {rx_r[6:0], link.so};
                  sck_r <= 1'b0;
                  cnt_r <= SCK_HALF - 1;
                  bib_r <= bib_r + 3'h1;
                  if (bib_r == 3'h7) begin
                     sh_r <= dat_r;
                     si_r <= dat_r[7];
                  end else begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     si_r <= sh_r[6];
                  end
                  bits_r <= bits_r - 6'h1;
                  st_r   <= (bits_r == 6'h0) ? HS_TAIL : HS_LOW;
               end
            end
            HS_TAIL: begin
               cnt_r <= cnt_r - 32'h1;
               if (cnt_r == 32'h0) begin
                  cs_r  <= 1'b1;
                  // after a wake keep deselected for t_res_a
                  cnt_r <= (op_r == OP_WAKE) ? T_RES_CYC - 1 : T_CS_CYC - 1;
                  st_r  <= HS_GAP;
               end
            end
            HS_GAP: begin
               cnt_r <= cnt_r - 32'h1;
               if (cnt_r == 32'h0) st_r <= HS_IDLE;
            end
            default: st_r <= HS_IDLE;
         endcase
      end
   end

   assign link.cs_n = cs_r;
   assign link.sck  = sck_r;
   assign link.si   = si_r;
endmodule : sfepc_host

// >>> test/sfepc_props.sv
// Purpose: checks on the serial link wires and the flash end state
// Assumes: one clock domain; sck comes from the host divider
// Notes:   sees interface wires and flash end outputs as plain inputs
`timescale 1ns/1ps
module sfepc_props import sfepc_pkg::*; #(
   parameter int unsigned T_PU_P = T_PU_CYC
) (
   input  wire logic       ref_clk_in,
   input  wire logic       nrst_in,
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic       si,
   input  wire logic       so,
   input  wire logic [7:0] status_out,
   input  wire logic       deep_out,
   input  wire logic       ready_out
);
   logic [7:0]  hi_cnt_r;
   logic [31:0] up_cnt_r;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////
   // cycles since deselect, saturating
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) hi_cnt_r <= 8'h00;
      else if (!cs_n) hi_cnt_r <= 8'h00;
      else if (hi_cnt_r != 8'hff) hi_cnt_r <= hi_cnt_r + 8'h01;
   end
   // cycles since power-up, stops at the power-up delay
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) up_cnt_r <= 32'h0;
      else if (up_cnt_r < T_PU_P) up_cnt_r <= up_cnt_r + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////
   a_so_quiet: assert property (hi_cnt_r >= 8'h06 |-> so == 1'b0)
      else $error("so driven while deselected");
   a_sck_idle: assert property (cs_n |-> !sck)
      else $error("sck high outside a frame");
   a_wel_before_busy: assert property ($rose(status_out[SB_BUSY]) |-> $past(status_out[SB_WLATCH]))
      else $error("cycle started without latch");
   a_wel_clear_end: assert property ($fell(status_out[SB_BUSY]) |-> !status_out[SB_WLATCH])
      else $error("latch still set at cycle end");
   a_no_busy_deep: assert property (status_out[SB_BUSY] |-> !deep_out)
      else $error("deep sleep with a cycle running");
   a_deep_not_ready: assert property (deep_out |-> !ready_out)
      else $error("ready while in deep sleep");
   a_wake_hold: assert property ($rose(cs_n) && deep_out |-> !ready_out [*8])
      else $error("wake without delay");
   a_pu_quiet: assert property (up_cnt_r < T_PU_P |-> !ready_out)
      else $error("ready before power-up delay");
   a_pu_state: assert property (up_cnt_r < T_PU_P |-> status_out == STATUS_RST && !deep_out)
      else $error("wrong power-up state");
   c_busy: cover property ($rose(status_out[SB_BUSY]));
   c_sleep: cover property ($rose(deep_out));
   c_wake: cover property ($fell(deep_out));
endmodule : sfepc_props

// >>> test/tb_serial_flash_erase_power_ctrl.sv
// Purpose: drives the host registers and checks the flash end behaviour
// Assumes: shortened power-up counts on both ends, shortened erase count on the flash end
// Notes:   wire monitor counts bits taken on sck rise, msb first
`timescale 1ns/1ps
module tb_serial_flash_erase_power_ctrl import sfepc_pkg::*; ();
   localparam int unsigned T_PU  = 100;
   localparam int unsigned T_BE  = 1000;
   localparam int          LIMIT = 30000;
   logic        ref_clk_in    = 1'b0;
   logic        nrst_in       = 1'b0;
   logic [3:0]  avs_address   = 4'h0;
   logic        avs_read      = 1'b0;
   logic        avs_write     = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  mem_idx       = 4'h0;
   logic        mem_wr        = 1'b0;
   logic [7:0]  mem_wdata     = 8'h00;
   logic [7:0]  mon_sr        = 8'h00;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, deep, ready;
   logic [7:0]  mem_rdata, status;
   int          mon_n = 0, n_errors = 0, num_checks = 0, cyc = 0;
   sfepc_link_if link ();
   sfepc_host #(.T_PU_P(T_PU)) u_sfepc_host (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
      .avs_waitrequest_out(avs_waitrequest), .link(link));
   sfepc_dev #(.T_PU_P(T_PU), .T_BE_P(T_BE)) u_sfepc_dev (.ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in), .link(link), .mem_idx_in(mem_idx), .mem_wr_in(mem_wr),
      .mem_wdata_in(mem_wdata), .mem_rdata_out(mem_rdata), .status_out(status),
      .deep_out(deep), .ready_out(ready));
   sfepc_props #(.T_PU_P(T_PU)) u_sfepc_props (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so(link.so), .status_out(status),
      .deep_out(deep), .ready_out(ready));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #10 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors = n_errors + 1;
         complete_run();
      end
   end
   // wire monitor
   always @(posedge link.sck) begin
      if (link.cs_n === 1'b0) begin
         mon_sr <= {mon_sr[6:0], link.si};
         mon_n <= mon_n + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      if (n_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   // one bus cycle, held until waitrequest low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge ref_clk_in);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk_in);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task automatic wait_host();
      do av(1'b0, HREG_STAT, 32'h0); while (q[0] !== 1'b0 || q[1] !== 1'b1);
      repeat (4) @(posedge ref_clk_in);
   endtask : wait_host
   task automatic cmd(input logic [7:0] op, input logic [1:0] nb, input logic [7:0] dat);
      mon_n = 0;
      av(1'b1, HREG_CMD, {8'h00, dat, 6'h00, nb, op});
      wait_host();
   endtask : cmd
   task automatic wait_dev();
      while (status[SB_BUSY] !== 1'b0) @(posedge ref_clk_in);
   endtask : wait_dev
   task automatic mem_at(input logic [3:0] i);
      mem_idx <= i;
      repeat (2) @(posedge ref_clk_in);
   endtask : mem_at
   // wake with n extra bytes; last byte seen on so lands in q[15:8]
   task automatic sig(input logic [2:0] n);
      mon_n = 0;
      av(1'b1, HREG_CMD, {21'h0, n, OP_WAKE});
      wait_host();
   endtask : sig
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      av(1'b1, HREG_CMD, 32'(OP_WR_EN));
      wait_host();
      check("early enable", 32'(status[SB_WLATCH]), 32'h0);
      // preset array away from erased
      for (int i = 0; i < MEM_BYTES; i++) begin
         mem_idx <= 4'(i);
         mem_wdata <= 8'(i);
         mem_wr <= 1'b1;
         @(posedge ref_clk_in);
      end
      mem_wr <= 1'b0;
      cmd(OP_ERASE, 2'h0, 8'h00);
      check("frame bits", 32'(mon_n), 32'h8);
      check("frame byte", 32'(mon_sr), 32'(OP_ERASE));
      mem_at(4'h3);
      check("erase no latch", 32'(mem_rdata), 32'h03);
      // protected array
      cmd(OP_WR_EN, 2'h0, 8'h00);
      check("latch set", 32'(status[SB_WLATCH]), 32'h1);
      cmd(OP_ST_WR, 2'h1, 8'h14);
      wait_dev();
      check("protect bits", 32'(status[SB_BP_LO +: BP_W]), 32'h5);
      cmd(OP_WR_EN, 2'h0, 8'h00);
      cmd(OP_ERASE, 2'h0, 8'h00);
      check("protected busy", 32'(status), 32'h16);
      mem_at(4'h3);
      check("protected byte", 32'(mem_rdata), 32'h03);
      cmd(OP_ST_WR, 2'h1, 8'h00);
      wait_dev();
      // erase with latch, sleep and wake refused meanwhile
      cmd(OP_WR_EN, 2'h0, 8'h00);
      cmd(OP_RDSR, 2'h1, 8'h00);
      check("link status", 32'(q[15:8]), 32'h02);
      cmd(OP_ERASE, 2'h0, 8'h00);
      check("erase started", 32'(status), 32'h01);
      cmd(OP_SLEEP, 2'h0, 8'h00);
      cmd(OP_WAKE, 2'h0, 8'h00);
      check("sleep in cycle", 32'(deep), 32'h0);
      cmd(OP_RDSR, 2'h1, 8'h00);
      check("busy on link", 32'(q[15:8]), 32'h01);
      wait_dev();
      for (int i = 0; i < MEM_BYTES; i++) begin
         mem_at(4'(i));
         check("erased byte", 32'(mem_rdata), 32'(MEM_ERASED));
      end
      // deep sleep and release
      cmd(OP_SLEEP, 2'h0, 8'h00);
      repeat (T_DP_CYC) @(posedge ref_clk_in);
      check("deep", {30'h0, deep, ready}, 32'h2);
      cmd(OP_WR_EN, 2'h0, 8'h00);
      check("enable in deep", 32'(status[SB_WLATCH]), 32'h0);
      cmd(OP_WAKE, 2'h0, 8'h00);
      repeat (10) @(posedge ref_clk_in);
      check("woken", {30'h0, deep, ready}, 32'h1);
      cmd(OP_WAKE, 2'h3, 8'h00);
      check("wake bits", 32'(mon_n), 32'h20);
      check("wake standby", 32'(ready), 32'h1);
      // signature after three dummies, then repeated
      sig(3'h4);
      check("sig bits", 32'(mon_n), 32'h28);
      check("signature", 32'(q[15:8]), 32'(SIGNATURE));
      sig(3'h5);
      check("sig repeat", 32'(q[15:8]), 32'(SIGNATURE));
      // signature read also releases deep sleep
      cmd(OP_SLEEP, 2'h0, 8'h00);
      repeat (T_DP_CYC) @(posedge ref_clk_in);
      sig(3'h4);
      check("deep signature", 32'(q[15:8]), 32'(SIGNATURE));
      repeat (10) @(posedge ref_clk_in);
      check("woken again", {30'h0, deep, ready}, 32'h1);
      complete_run();
   end
endmodule : tb_serial_flash_erase_power_ctrl
